// ==== core/flash_led_driver_consts.vh ====
`ifndef FLASH_LED_DRIVER_CONSTS_VH
`define FLASH_LED_DRIVER_CONSTS_VH

// bus address, seven bits, sent in bits 7..1 of the first byte
`define I2C_SLAVE_ADDR   7'h28
`define BITS_PER_BYTE    4'h8
`define FIRST_DATA_BIT   4'h1

// data byte order within one bus command
`define IDX_MODE         2'h0
`define IDX_FLASH        2'h1
`define IDX_TORCH        2'h2
`define IDX_STATUS       2'h3

// mode_gain_timeout_control fields
`define MODE_FUNC_HI     7
`define MODE_FUNC_LO     6
`define MODE_RETAIN_BIT  5
`define MODE_GAIN_HI     4
`define MODE_GAIN_LO     3
`define MODE_TMO_HI      1
`define MODE_TMO_LO      0
`define FUNC_NONE        2'h0
`define FUNC_HE_TORCH    2'h1
`define FUNC_AG_TORCH    2'h2
`define FUNC_FLASH       2'h3
`define TMO_SEL_0        2'h0
`define TMO_SEL_1        2'h1
`define TMO_SEL_2        2'h2

// channel enable and current code fields
`define EN_HI            7
`define EN_LO            5
`define FCODE_HI         4
`define FCODE_LO         2
`define TCODE_HI         4
`define TCODE_LO         1

// flash_level_and_fault_status fields
`define STAT_VLIM_HI     7
`define STAT_VLIM_LO     5

// writable bits; the rest are dropped on write and read as zero
`define MODE_WMASK       8'hfb
`define FLASH_WMASK      8'hfc
`define TORCH_WMASK      8'hfe

`define REG_RESET        8'h00
`define CH_MASK_3        3'h7
`define CH_MASK_2        3'h6

// flash timeouts in 50 MHz ref_clk cycles: 0.11, 0.22, 0.53 and 1.10 s
`define FLASH_TMO0_CYC   26'h53ec60
`define FLASH_TMO1_CYC   26'ha7d8c0
`define FLASH_TMO2_CYC   26'h1945ba0
`define FLASH_TMO3_CYC   26'h3473bc0
`define TMO_W            26

// scl and sda idle high; their synchronisers reset there so no false edge follows reset
`define SYNC_IDLE_LEVELS 7'h03

`endif

// ==== core/flash_led_driver_control_regs.v ====
`timescale 1ns/1ps
`include "flash_led_driver_consts.vh"

module flash_led_driver_control_regs #(
  parameter                CHANNELS = 3,
  parameter [`TMO_W-1:0]   TMO0_CYC = `FLASH_TMO0_CYC,
  parameter [`TMO_W-1:0]   TMO1_CYC = `FLASH_TMO1_CYC,
  parameter [`TMO_W-1:0]   TMO2_CYC = `FLASH_TMO2_CYC,
  parameter [`TMO_W-1:0]   TMO3_CYC = `FLASH_TMO3_CYC
) (
  input  wire              ref_clk,
  input  wire              arst_n,
  input  wire              scl_in,
  input  wire              sda_in,
  output reg               sda_out,
  output reg               sda_oe,
  input  wire              chip_enable_n,
  input  wire              flash_trigger,
  input  wire              vout_over_limit,
  input  wire              input_undervoltage_lockout,
  input  wire              overtemp_fault,
  output reg  [2:0]        led_channel_on,
  output reg  [3:0]        led_current_code,
  output reg  [1:0]        pump_gain,
  output reg  [2:0]        vout_limit_code,
  output reg               flash_active,
  output reg               torch_active,
  output reg               high_eff_torch,
  output reg               standby,
  output reg               shutdown
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_WR   = 7'h08;
  localparam [6:0] ST_WACK = 7'h10;
  localparam [6:0] ST_RD   = 7'h20;
  localparam [6:0] ST_RACK = 7'h40;

  localparam [2:0] CH_MASK = (CHANNELS >= 3) ? `CH_MASK_3 : `CH_MASK_2;

  function [7:0] masked;
    input [7:0] data;
    input [7:0] mask;
    begin
      masked = data & mask;
    end
  endfunction

  // every pin input is asynchronous to ref_clk
  wire [6:0] async_in = {overtemp_fault, input_undervoltage_lockout, vout_over_limit,
                         flash_trigger, chip_enable_n, sda_in, scl_in};
  localparam [6:0] SYNC_IDLE = `SYNC_IDLE_LEVELS;
  wire [6:0] sync_out;

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_sync
      reg meta_reg;
      reg stable_reg;
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_reg   <= SYNC_IDLE[g];
          stable_reg <= SYNC_IDLE[g];
        end else begin
          meta_reg   <= async_in[g];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[g] = stable_reg;
    end
  endgenerate

  wire scl_s  = sync_out[0];
  wire sda_s  = sync_out[1];
  wire en_s   = sync_out[2];
  wire trig_s = sync_out[3];
  wire over_s = sync_out[4];
  wire input_undervoltage_lockout_s = sync_out[5];
  wire temp_s = sync_out[6];

  reg scl_d_reg;
  reg sda_d_reg;
  reg trig_d_reg;

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire trig_rise = trig_s & ~trig_d_reg;

  reg  [6:0]        state_reg;
  reg  [7:0]        shift_reg;
  reg  [3:0]        bit_cnt_reg;
  reg               rw_reg;
  reg  [1:0]        idx_reg;
  reg               nack_reg;
  reg  [7:0]        mode_reg;
  reg  [7:0]        flash_reg;
  reg  [7:0]        torch_reg;
  reg  [2:0]        vlim_reg;
  reg               flash_on_reg;
  reg  [`TMO_W-1:0] tmo_cnt_reg;

  wire        retain = mode_reg[`MODE_RETAIN_BIT];
  wire [1:0]  func   = mode_reg[`MODE_FUNC_HI:`MODE_FUNC_LO];

  // status bits 4..2 are live fault and limit levels, bits 1..0 are zero
  wire [7:0] status_byte = {vlim_reg, over_s, input_undervoltage_lockout_s, temp_s, 2'h0};

  reg [7:0] rd_byte;
  always @* begin
    case (idx_reg)
      `IDX_MODE:  rd_byte = mode_reg;
      `IDX_FLASH: rd_byte = flash_reg;
      `IDX_TORCH: rd_byte = torch_reg;
      default:    rd_byte = status_byte;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_reg  <= SYNC_IDLE[0];
      sda_d_reg  <= SYNC_IDLE[1];
      trig_d_reg <= 1'b0;
    end else begin
      scl_d_reg  <= scl_s;
      sda_d_reg  <= sda_s;
      trig_d_reg <= trig_s;
    end
  end

  // bus slave and register file
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= ST_IDLE;
      shift_reg   <= `REG_RESET;
      bit_cnt_reg <= 4'h0;
      rw_reg      <= 1'b0;
      idx_reg     <= `IDX_MODE;
      nack_reg    <= 1'b0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
      mode_reg    <= `REG_RESET;
      flash_reg   <= `REG_RESET;
      torch_reg   <= `REG_RESET;
      vlim_reg    <= 3'h0;
    end else begin
      sda_out <= 1'b0;
      if (bus_start) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        idx_reg     <= `IDX_MODE;
        sda_oe      <= 1'b0;
        if (!retain) begin
          mode_reg  <= `REG_RESET;
          flash_reg <= `REG_RESET;
          torch_reg <= `REG_RESET;
          vlim_reg  <= 3'h0;
        end
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
              if (shift_reg[7:1] == `I2C_SLAVE_ADDR) begin
                state_reg <= ST_AACK;
                rw_reg    <= shift_reg[0];
                sda_oe    <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                state_reg   <= ST_RD;
                shift_reg   <= rd_byte;
                sda_oe      <= ~rd_byte[7];
                bit_cnt_reg <= `FIRST_DATA_BIT;
              end else begin
                state_reg   <= ST_WR;
                sda_oe      <= 1'b0;
                bit_cnt_reg <= 4'h0;
              end
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
              state_reg <= ST_WACK;
              sda_oe    <= 1'b1;
              idx_reg   <= idx_reg + 2'h1;
              case (idx_reg)
                `IDX_MODE:  mode_reg  <= masked(shift_reg, `MODE_WMASK);
                `IDX_FLASH: flash_reg <= masked(shift_reg, `FLASH_WMASK);
                `IDX_TORCH: torch_reg <= masked(shift_reg, `TORCH_WMASK);
                default:    vlim_reg  <= shift_reg[`STAT_VLIM_HI:`STAT_VLIM_LO];
              endcase
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              state_reg   <= ST_WR;
              sda_oe      <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt_reg == `BITS_PER_BYTE) begin
                state_reg <= ST_RACK;
                sda_oe    <= 1'b0;
                idx_reg   <= idx_reg + 2'h1;
              end else begin
                sda_oe      <= ~shift_reg[6];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_reg <= sda_s;
            end else if (scl_fall) begin
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg   <= ST_RD;
                shift_reg   <= rd_byte;
                sda_oe      <= ~rd_byte[7];
                bit_cnt_reg <= `FIRST_DATA_BIT;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sda_oe    <= 1'b0;
          end
        endcase
      end
      // shutdown wipes the registers unless retention is set; placed last so it wins
      if (!en_s && !retain) begin
        mode_reg  <= `REG_RESET;
        flash_reg <= `REG_RESET;
        torch_reg <= `REG_RESET;
        vlim_reg  <= 3'h0;
      end
    end
  end

  wire flash_mode = (func == `FUNC_FLASH);
  wire torch_mode = (func == `FUNC_HE_TORCH) || (func == `FUNC_AG_TORCH);
  wire [2:0] flash_en = flash_reg[`EN_HI:`EN_LO] & CH_MASK;
  wire [2:0] torch_en = torch_reg[`EN_HI:`EN_LO] & CH_MASK;

  reg [`TMO_W-1:0] tmo_sel;
  always @* begin
    case (mode_reg[`MODE_TMO_HI:`MODE_TMO_LO])
      `TMO_SEL_0: tmo_sel = TMO0_CYC;
      `TMO_SEL_1: tmo_sel = TMO1_CYC;
      `TMO_SEL_2: tmo_sel = TMO2_CYC;
      default:    tmo_sel = TMO3_CYC;
    endcase
  end

  // a flash runs to its timeout; a held trigger does not retrigger it
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_on_reg <= 1'b0;
      tmo_cnt_reg  <= {`TMO_W{1'b0}};
    end else if (!en_s || !flash_mode) begin
      flash_on_reg <= 1'b0;
      tmo_cnt_reg  <= {`TMO_W{1'b0}};
    end else if (flash_on_reg) begin
      if (tmo_cnt_reg == {`TMO_W{1'b0}}) begin
        flash_on_reg <= 1'b0;
      end else begin
        tmo_cnt_reg <= tmo_cnt_reg - {{(`TMO_W-1){1'b0}}, 1'b1};
      end
    end else if (trig_rise && flash_en != 3'h0) begin
      flash_on_reg <= 1'b1;
      tmo_cnt_reg  <= tmo_sel - {{(`TMO_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      led_channel_on   <= 3'h0;
      led_current_code <= 4'h0;
      pump_gain        <= 2'h0;
      vout_limit_code  <= 3'h0;
      flash_active     <= 1'b0;
      torch_active     <= 1'b0;
      high_eff_torch   <= 1'b0;
      standby          <= 1'b1;
      shutdown         <= 1'b1;
    end else begin
      shutdown        <= ~en_s;
      pump_gain       <= mode_reg[`MODE_GAIN_HI:`MODE_GAIN_LO];
      vout_limit_code <= vlim_reg;
      high_eff_torch  <= (func == `FUNC_HE_TORCH);
      // gated by the mode too, so a mode change never shows flash and torch together
      flash_active    <= en_s & flash_mode & flash_on_reg;
      torch_active    <= en_s & torch_mode & (torch_en != 3'h0);
      // flash register only matters in flash mode
      standby <= flash_mode ? (flash_en == 3'h0) :
                 torch_mode ? (torch_en == 3'h0) : 1'b1;
      if (!en_s) begin
        led_channel_on <= 3'h0;
      end else if (flash_mode) begin
        led_channel_on <= flash_on_reg ? flash_en : 3'h0;
      end else if (torch_mode) begin
        led_channel_on <= torch_en;
      end else begin
        led_channel_on <= 3'h0;
      end
      if (flash_mode) begin
        led_current_code <= {1'b0, flash_reg[`FCODE_HI:`FCODE_LO]};
      end else begin
        led_current_code <= torch_reg[`TCODE_HI:`TCODE_LO];
      end
    end
  end

endmodule // flash_led_driver_control_regs

// ==== testbench/flash_led_driver_control_regs_assertions.sv ====
`timescale 1ns/1ps
module flash_led_driver_control_regs_assertions #(
  parameter CHANNELS = 3,
  parameter TMO3_CYC = 400
) (
  input wire       ref_clk,
  input wire       arst_n,
  input wire       chip_enable_n,
  input wire       sda_out,
  input wire [2:0] led_channel_on,
  input wire       flash_active,
  input wire       torch_active,
  input wire       high_eff_torch,
  input wire       standby,
  input wire       shutdown
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  int run_cnt;
  // length of the current flash window, zero outside it
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n) run_cnt <= 0;
    else run_cnt <= flash_active ? run_cnt + 1 : 0;
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_standby_dark: assert property (standby |-> led_channel_on == 3'h0)
    else $error("channel lit in standby");
  a_shutdown_dark: assert property (!chip_enable_n [*6] |-> shutdown && led_channel_on == 3'h0)
    else $error("not dark in shutdown");
  a_enable_wakes: assert property ($rose(chip_enable_n) |-> ##[2:5] !shutdown)
    else $error("shutdown stuck after enable");
  a_flash_bound: assert property (run_cnt <= TMO3_CYC)
    else $error("flash window too long");
  a_flash_lit: assert property ($rose(flash_active) |-> led_channel_on != 3'h0 && !torch_active)
    else $error("flash without channels");
  a_ch3_masked: assert property (CHANNELS == 2 |-> !led_channel_on[0])
    else $error("third channel on two-channel part");
  a_torch_lit: assert property (torch_active |-> led_channel_on != 3'h0 && !standby && !flash_active)
    else $error("torch flag inconsistent");
  a_he_not_flash: assert property (high_eff_torch |-> !flash_active)
    else $error("efficient torch during flash");
  c_flash: cover property ($rose(flash_active));
  c_torch: cover property ($rose(torch_active));
  c_standby: cover property ($rose(standby));
  c_wake: cover property (shutdown ##1 !shutdown);
endmodule // flash_led_driver_control_regs_assertions

// ==== testbench/flash_led_driver_control_regs_tb.sv ====
`timescale 1ns/1ps
module flash_led_driver_control_regs_tb;
  localparam logic [3:0][25:0] TMO_TAB = {26'h190, 26'hc8, 26'h64, 26'h32};
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        chip_enable_n = 1'b1;
  logic        flash_trigger = 1'b0;
  logic        vout_over_limit = 1'b0;
  logic        input_undervoltage_lockout = 1'b0;
  logic        overtemp_fault = 1'b0;
  wire         scl, sda_low, sda_out, sda_oe;
  wire         flash_active, torch_active, high_eff_torch, standby, shutdown;
  wire  [2:0]  led_channel_on, vout_limit_code;
  wire  [3:0]  led_current_code;
  wire  [1:0]  pump_gain;
  wire         sda_oe_two;
  wire  [2:0]  led_two;
  wire         sda_line = ~(sda_oe | sda_oe_two | sda_low);
  int          fail_count = 0;
  int          n_checks = 0;
  int          k;
  logic [31:0] q;
  logic [7:0]  tm [3] = '{8'h60, 8'h20, 8'ha0};
  logic [7:0]  tt [3] = '{8'h5e, 8'h5e, 8'h1e};
  logic [2:0]  ton [3] = '{3'h2, 3'h0, 3'h0};
  always #10 ref_clk = ~ref_clk;
  i2c_master_model m (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  flash_led_driver_control_regs #(.CHANNELS(3), .TMO0_CYC(TMO_TAB[0]), .TMO1_CYC(TMO_TAB[1]),
    .TMO2_CYC(TMO_TAB[2]), .TMO3_CYC(TMO_TAB[3])) u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_enable_n(chip_enable_n),
    .flash_trigger(flash_trigger), .vout_over_limit(vout_over_limit),
    .input_undervoltage_lockout(input_undervoltage_lockout),
    .overtemp_fault(overtemp_fault), .led_channel_on(led_channel_on),
    .led_current_code(led_current_code), .pump_gain(pump_gain),
    .vout_limit_code(vout_limit_code), .flash_active(flash_active),
    .torch_active(torch_active), .high_eff_torch(high_eff_torch),
    .standby(standby), .shutdown(shutdown));
  // two-channel build on the same bus; it stores the same bytes, so reads agree
  flash_led_driver_control_regs #(.CHANNELS(2), .TMO0_CYC(TMO_TAB[0]), .TMO1_CYC(TMO_TAB[1]),
    .TMO2_CYC(TMO_TAB[2]), .TMO3_CYC(TMO_TAB[3])) u_dut_two (
    .ref_clk(ref_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(), .sda_oe(sda_oe_two), .chip_enable_n(chip_enable_n),
    .flash_trigger(flash_trigger), .vout_over_limit(vout_over_limit),
    .input_undervoltage_lockout(input_undervoltage_lockout),
    .overtemp_fault(overtemp_fault), .led_channel_on(led_two),
    .led_current_code(), .pump_gain(), .vout_limit_code(), .flash_active(),
    .torch_active(), .high_eff_torch(), .standby(), .shutdown());
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic bus_write(input int n, input logic [31:0] d);
    logic a;
    m.start_c;
    m.write_byte(8'h50, a);
    check(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.write_byte(d[31-8*i -: 8], a);
      check(a, 1'b1);
    end
    m.stop_c;
  endtask
  task automatic bus_read(output logic [31:0] r);
    logic a;
    m.start_c;
    m.write_byte(8'h51, a);
    check(a, 1'b1);
    for (int i = 0; i < 4; i++) m.read_byte(i == 3, r[31-8*i -: 8]);
    m.stop_c;
  endtask
  initial begin
    logic a;
    settle(2);
    arst_n <= 1'b1;
    settle(5);
    bus_read(q);
    check(q, 32'h0000_0000);
    m.start_c;
    m.write_byte(8'h52, a);
    check(a, 1'b0);
    m.stop_c;
    vout_over_limit <= 1'b1;
    overtemp_fault <= 1'b1;
    bus_write(4, 32'hffff_ffff);
    bus_read(q);
    check(q, 32'hfbfc_fef4);
    check(pump_gain, 2'h3);
    check(vout_limit_code, 3'h7);
    @(posedge ref_clk);
    chip_enable_n <= 1'b0;
    settle(8);
    check(shutdown, 1'b1);
    check(led_channel_on, 3'h0);
    @(posedge ref_clk);
    chip_enable_n <= 1'b1;
    settle(8);
    bus_read(q);
    check(q, 32'hfbfc_fef4);
    for (int t = 0; t < 4; t++) begin
      bus_write(3, {8'he0 | 8'(t), 8'ha4, 16'h0000});
      @(posedge ref_clk);
      flash_trigger <= 1'b1;
      k = 0;
      while (flash_active !== 1'b1 && k < 20) begin
        settle(1);
        k++;
      end
      check(led_channel_on, 3'h5);
      check(led_two, 3'h4);
      check(led_current_code, 4'h1);
      k = 0;
      while (flash_active === 1'b1 && k < 1000) begin
        @(posedge ref_clk);
        flash_trigger <= 1'b0;
        #1;
        k++;
      end
      check(k, TMO_TAB[t]);
      check(led_channel_on, 3'h0);
    end
    for (int i = 0; i < 3; i++) begin
      bus_write(3, {tm[i], 8'ha4, tt[i], 8'h00});
      settle(4);
      check(led_channel_on, ton[i]);
      check(standby, i != 0);
      check(torch_active, i == 0);
      check(high_eff_torch, i == 0);
      if (i == 0) check(led_current_code, 4'hf);
    end
    @(posedge ref_clk);
    vout_over_limit <= 1'b0;
    overtemp_fault <= 1'b0;
    input_undervoltage_lockout <= 1'b1;
    bus_write(1, 32'h0300_0000);
    bus_read(q);
    check(q, 32'h0000_0008);
    bus_write(1, 32'h1800_0000);
    settle(2);
    check(pump_gain, 2'h3);
    @(posedge ref_clk);
    chip_enable_n <= 1'b0;
    settle(8);
    check(pump_gain, 2'h0);
    check(shutdown, 1'b1);
    give_verdict;
  end
  initial begin
    #2_000_000;
    fail_count++;
    give_verdict;
  end
endmodule // flash_led_driver_control_regs_tb

bind flash_led_driver_control_regs flash_led_driver_control_regs_assertions #(
  .CHANNELS(CHANNELS), .TMO3_CYC(TMO3_CYC)) u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .chip_enable_n(chip_enable_n), .sda_out(sda_out),
  .led_channel_on(led_channel_on), .flash_active(flash_active), .torch_active(torch_active),
  .high_eff_torch(high_eff_torch), .standby(standby), .shutdown(shutdown));

// ==== testbench/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
  input  wire ref_clk,
  input  wire sda_line,
  output reg  scl,
  output reg  sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic start_c;
    w(1);
    sda_low <= 1'b1;
    w(10);
    scl <= 1'b0;
  endtask
  task automatic stop_c;
    w(2);
    sda_low <= 1'b1;
    w(8);
    scl <= 1'b1;
    w(10);
    sda_low <= 1'b0;
    w(10);
  endtask
  // data moves two cycles after the clock fall so no start is mimicked
  task automatic bit_c(input logic b, output logic r);
    w(2);
    sda_low <= ~b;
    w(8);
    scl <= 1'b1;
    w(10);
    r = sda_line;
    scl <= 1'b0;
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(d[i], r);
    bit_c(1'b1, r);
    ack = ~r;
  endtask
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
    bit_c(last, r);
  endtask
endmodule // i2c_master_model
